// file: common/fsb_regs.svh
// Constants of the flexible serial block: reset values, counter top, edge counts per byte and the output bit position.
// Assumes inclusion by bare name from the package and the design files.
`ifndef FSB_REGS_SVH
`define FSB_REGS_SVH

`define FSB_DATA_RST 8'h00
`define FSB_CNT_RST 4'h0
`define FSB_CNT_TOP 4'hF
`define FSB_MSB_POS 7
`define FSB_CNT_BYTE_EXT 16
`define FSB_CNT_BYTE_INT 8

`endif

// file: common/fsb_pkg.sv
// Types shared by the flexible serial block.
// Assumes the constants header is on the include path.
`include "fsb_regs.svh"

package fsb_pkg;

    // Shift clock source, as software selects it.
    typedef enum logic [1:0] {
        FSB_SRC_PIN = 2'h0,
        FSB_SRC_TIMER = 2'h1,
        FSB_SRC_SOFT = 2'h2
    } fsb_clk_src_e;

    // Wire mode of the output stage.
    typedef enum logic {
        FSB_WIRE_THREE = 1'h0,
        FSB_WIRE_TWO = 1'h1
    } fsb_wire_e;

endpackage

// file: verilog/fsb_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps

module fsb_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // Elaboration check: a synchroniser needs at least one bit.
    if (W < 1) begin : g_bad_width
        $error("fsb_sync: width must be at least one");
    end

    logic [W-1:0] meta_q;

    // The first stage feeds only the second; nothing else looks at it.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// file: verilog/fsb_top.sv
// Flexible serial block: shift register, edge counter, clock selection and
// the two-wire clock control with start detection.
// Assumes the processor side runs on clk_sys; serial pins are asynchronous.
`timescale 1ns/1ps
`include "fsb_regs.svh"

module fsb_top #(
    parameter int DATA_W = 8,
    parameter int CNT_W = 4
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic data_wr,
    input wire logic [DATA_W-1:0] data_wdata,
    output logic [DATA_W-1:0] shift_data_reg,
    input wire logic cnt_wr,
    input wire logic [CNT_W-1:0] cnt_wdata,
    output logic [CNT_W-1:0] cnt_value,
    input wire fsb_pkg::fsb_wire_e wire_mode,
    input wire fsb_pkg::fsb_clk_src_e clk_src,
    input wire logic clock_edge_select,
    input wire logic timer0_match,
    input wire logic soft_strobe,
    input wire logic ovf_clear,
    input wire logic start_clear,
    input wire logic ovf_irq_en,
    input wire logic start_irq_en,
    input wire logic hold_after_start,
    input wire logic hold_after_ovf,
    input wire logic deep_sleep,
    input wire logic serial_in_pin,
    input wire logic serial_clock_pin,
    output logic counter_overflow_flag,
    output logic start_detect_flag,
    output logic irq_req,
    output logic wake_req,
    output logic three_wire_out,
    output logic sda_o,
    output logic sda_oe_n,
    output logic scl_o,
    output logic scl_oe_n
);

    // Elaboration check: the byte size and the counter width must match.
    // The reset values and the output bit position are fixed for an 8-bit byte.
    if (DATA_W != `FSB_MSB_POS + 1 || CNT_W < 1 || (1 << CNT_W) != 2 * DATA_W) begin : g_bad_params
        $error("fsb_top: byte width or counter width not supported");
    end

    logic sck_s;
    logic din_s;
    logic sck_prev_q;
    logic din_prev_q;
    logic sck_rise;
    logic sck_fall;
    logic sample_edge;
    logic int_strobe;
    logic shift_evt;
    logic cnt_evt;
    logic cnt_wrap;
    logic start_cond;
    logic latch_open;
    logic pending;
    logic two_wire;

    // True when the source is generated inside the chip, not by the pin.
    function automatic logic is_internal(input fsb_pkg::fsb_clk_src_e src);
        return src != fsb_pkg::FSB_SRC_PIN;
    endfunction

    // Pins are synchronised; only the second stage reaches the logic below.
    fsb_sync #(
        .W(2),
        .RST_VAL(2'h3)
    ) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .async_in({serial_clock_pin, serial_in_pin}),
        .sync_out({sck_s, din_s})
    );

    // Previous pin levels for edge finding.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sck_prev_q <= 1'h1;
            din_prev_q <= 1'h1;
        end else begin
            sck_prev_q <= sck_s;
            din_prev_q <= din_s;
        end
    end

    assign two_wire = wire_mode == fsb_pkg::FSB_WIRE_TWO;
    assign sck_rise = sck_s && !sck_prev_q;
    assign sck_fall = !sck_s && sck_prev_q;
    assign sample_edge = clock_edge_select ? sck_fall : sck_rise;
    assign int_strobe = (clk_src == fsb_pkg::FSB_SRC_TIMER && timer0_match) ||
                        (clk_src == fsb_pkg::FSB_SRC_SOFT && soft_strobe);
    assign shift_evt = is_internal(clk_src) ? int_strobe : sample_edge;
    assign cnt_evt = is_internal(clk_src) ? int_strobe : (sck_rise || sck_fall);
    assign cnt_wrap = cnt_evt && !cnt_wr && cnt_value == `FSB_CNT_TOP;
    // start is SDA falling while SCL stays high
    assign start_cond = two_wire && !din_s && din_prev_q && sck_s && sck_prev_q;
    // latch open in the output phase of the pin clock
    assign latch_open = is_internal(clk_src) || (sck_s == clock_edge_select);
    assign pending = (counter_overflow_flag && ovf_irq_en) ||
                     (start_detect_flag && start_irq_en);

    // Shift register: a processor write wins over a shift in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            shift_data_reg <= `FSB_DATA_RST;
        end else if (data_wr) begin
            shift_data_reg <= data_wdata;
        end else if (shift_evt) begin
            shift_data_reg <= {shift_data_reg[DATA_W-2:0], din_s};
        end
    end

    // Edge counter; a write from software takes the counter that cycle.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_value <= `FSB_CNT_RST;
        end else if (cnt_wr) begin
            cnt_value <= cnt_wdata;
        end else if (cnt_evt) begin
            cnt_value <= cnt_value + 1'h1;
        end
    end

    // Sticky flags: an event in the clearing cycle keeps the flag set.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            counter_overflow_flag <= 1'h0;
            start_detect_flag <= 1'h0;
        end else begin
            if (cnt_wrap) begin
                counter_overflow_flag <= 1'h1;
            end else if (ovf_clear) begin
                counter_overflow_flag <= 1'h0;
            end
            if (start_cond) begin
                start_detect_flag <= 1'h1;
            end else if (start_clear) begin
                start_detect_flag <= 1'h0;
            end
        end
    end

    // Output latch: with the pin clock, only moves in the phase opposite the sampling edge; an internal source keeps it open.
    // Leaving two-wire mode lets go of SDA at once, so a parked clock cannot hold it low.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            three_wire_out <= 1'h1;
            sda_oe_n <= 1'h1;
        end else begin
            if (latch_open && !two_wire) begin
                three_wire_out <= shift_data_reg[`FSB_MSB_POS];
            end
            if (!two_wire) begin
                sda_oe_n <= 1'h1;
            end else if (latch_open) begin
                sda_oe_n <= shift_data_reg[`FSB_MSB_POS];
            end
        end
    end

    // Open-drain lines only ever pull low, so their data outputs stay zero.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sda_o <= 1'h0;
            scl_o <= 1'h0;
        end else begin
            sda_o <= 1'h0;
            scl_o <= 1'h0;
        end
    end

    // wait states hold SCL low
    // The hold ends when software clears the flag or its hold enable, or leaves two-wire mode, as a slave must.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            scl_oe_n <= 1'h1;
        end else begin
            scl_oe_n <= !(two_wire && ((hold_after_start && start_detect_flag) ||
                                       (hold_after_ovf && counter_overflow_flag)));
        end
    end

    // wake depends on wire mode
    // A deep sleep leaves only the two-wire events able to wake the core.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_req <= 1'h0;
            wake_req <= 1'h0;
        end else begin
            irq_req <= pending;
            wake_req <= pending && (two_wire || !deep_sleep);
        end
    end

    // Assertions guarding the behaviour above.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    property p_data_write;
        data_wr |=> shift_data_reg == $past(data_wdata);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write lost");

    property p_shift_in;
        shift_evt && !data_wr |=>
            shift_data_reg == {$past(shift_data_reg[DATA_W-2:0]), $past(din_s)};
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift did not take pin bit");

    property p_pin_select;
        !two_wire ##1 !two_wire |-> sda_oe_n;
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("SDA driven in three-wire");

    property p_latch_closed;
        !latch_open |=> $stable(three_wire_out) && ($stable(sda_oe_n) || !$past(two_wire));
    endproperty
    a_latch_closed: assert property (p_latch_closed) else $error("latch moved when closed");

    property p_both_edges;
        !is_internal(clk_src) && sck_fall && !cnt_wr |=>
            cnt_value == $past(cnt_value) + 1'h1;
    endproperty
    a_both_edges: assert property (p_both_edges) else $error("falling edge not counted");

    property p_wrap;
        cnt_wrap |=> cnt_value == `FSB_CNT_RST && counter_overflow_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("overflow wrap or flag wrong");

    property p_soft_strobe;
        clk_src == fsb_pkg::FSB_SRC_SOFT && soft_strobe && !cnt_wr |=>
            cnt_value == $past(cnt_value) + 1'h1;
    endproperty
    a_soft_strobe: assert property (p_soft_strobe) else $error("strobe not counted");

    property p_start_flag;
        start_cond |=> start_detect_flag ##1 (irq_req == start_irq_en || counter_overflow_flag);
    endproperty
    a_start_flag: assert property (p_start_flag) else $error("start not flagged");

    property p_hold;
        two_wire && hold_after_ovf && counter_overflow_flag |=> !scl_oe_n;
    endproperty
    a_hold: assert property (p_hold) else $error("SCL not held after overflow");

    property p_wake;
        pending && two_wire |=> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("two-wire wake missing");

    c_byte_done: cover property (cnt_wrap && !is_internal(clk_src));
    c_start_hold: cover property (start_cond ##[1:20] !scl_oe_n);
    c_soft_byte: cover property (cnt_wrap && clk_src == fsb_pkg::FSB_SRC_SOFT);
    c_set_vs_clear: cover property (cnt_wrap && ovf_clear);

endmodule

// file: verification/fsb_far_end.sv
// Far-end serial master: clocks byte frames and makes start conditions.
// Assumes the device samples both pins through its own synchronisers.
`timescale 1ns/1ps

module fsb_far_end (
    output logic sck,
    output logic sdi,
    input wire logic sdo,
    output logic [7:0] rx
);
    // Lines idle high, as the device assumes its pins are after reset.
    initial begin
        sck = 1'b1;
        sdi = 1'b1;
        rx = 8'h00;
    end

    // The clock stands still between frames at the chosen idle level.
    task automatic park(input logic lvl);
        sck = lvl;
    endtask

    // eight pulses a byte
    // Data leads the sample edge by half a period; the device bit is taken just before it.
    task automatic frame(input logic [7:0] tx, input logic sel);
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #100;
            rx = {rx[6:0], sdo};
            sck = ~sel;
            #100;
            sck = sel;
        end
        #100;
        sdi = ~tx[0];
    endtask

    // Data falls while the clock stays high.
    task automatic start_cond();
        sck = 1'b1;
        sdi = 1'b1;
        #200;
        sdi = 1'b0;
        #200;
    endtask
endmodule

// file: verification/fsb_top_test.sv
// Self-checking bench of the flexible serial block against a far-end master.
// Assumes the package, the design and the far-end model are compiled first.
`timescale 1ns/1ps

module fsb_top_test;
    logic clk_sys = 1'b0, srst = 1'b1, data_wr = 1'b0, cnt_wr = 1'b0;
    logic timer0_match = 1'b0, soft_strobe = 1'b0, ovf_clear = 1'b0, start_clear = 1'b0;
    logic ovf_irq_en = 1'b0, start_irq_en = 1'b0, hold_after_start = 1'b0;
    logic hold_after_ovf = 1'b0, deep_sleep = 1'b0, clock_edge_select = 1'b0;
    logic [7:0] data_wdata = 8'h00, shift_data_reg, far_rx;
    logic [3:0] cnt_wdata = 4'h0, cnt_value;
    fsb_pkg::fsb_wire_e wire_mode = fsb_pkg::FSB_WIRE_THREE;
    fsb_pkg::fsb_clk_src_e clk_src = fsb_pkg::FSB_SRC_SOFT;
    logic serial_in_pin, serial_clock_pin, far_sda, far_scl, counter_overflow_flag;
    logic start_detect_flag, irq_req, wake_req, three_wire_out, sda_o, sda_oe_n, scl_o, scl_oe_n;
    int err_total = 0, checks_done = 0, cycles = 0;

    // Open-drain wires: either party may pull a line low.
    assign serial_in_pin = far_sda & (sda_oe_n | sda_o);
    assign serial_clock_pin = far_scl & (scl_oe_n | scl_o);

    fsb_top fsb_top_inst (
        .clk_sys, .srst, .data_wr, .data_wdata, .shift_data_reg, .cnt_wr, .cnt_wdata,
        .cnt_value, .wire_mode, .clk_src, .clock_edge_select, .timer0_match, .soft_strobe,
        .ovf_clear, .start_clear, .ovf_irq_en, .start_irq_en, .hold_after_start,
        .hold_after_ovf, .deep_sleep, .serial_in_pin, .serial_clock_pin,
        .counter_overflow_flag, .start_detect_flag, .irq_req, .wake_req, .three_wire_out,
        .sda_o, .sda_oe_n, .scl_o, .scl_oe_n
    );
    fsb_far_end fsb_far_end_inst (.sck(far_scl), .sdi(far_sda), .sdo(three_wire_out), .rx(far_rx));

    // System clock at 40 MHz.
    always #12.5 clk_sys = ~clk_sys;

    // A hang counts as a mismatch and still ends in the closing report.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end

    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask

    // Pulses end on a falling edge, so a following pulse never lands in the same step.
    task automatic pulse(ref logic s, input int n);
        @(negedge clk_sys);
        s = 1'b1;
        repeat (n) @(negedge clk_sys);
        s = 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic t_reset();
        check("data", shift_data_reg, 8'h00);
        check("cnt", cnt_value, 8'h00);
        check("ovf", counter_overflow_flag, 8'h00);
        check("dout", three_wire_out, 8'h01);
        check("scl_oe_n", scl_oe_n, 8'h01);
        $display("done reset");
    endtask

    task automatic t_strobe();
        data_wdata = 8'hA5;
        pulse(data_wr, 1);
        cnt_wdata = 4'h8;
        pulse(cnt_wr, 1);
        check("data", shift_data_reg, 8'hA5);
        pulse(soft_strobe, 4);
        tick(2);
        check("data", shift_data_reg, 8'h5F);
        check("cnt", cnt_value, 8'h0C);
        check("dout", three_wire_out, 8'h00);
        clk_src = fsb_pkg::FSB_SRC_TIMER;
        pulse(soft_strobe, 1);
        tick(2);
        check("data", shift_data_reg, 8'h5F);
        pulse(timer0_match, 4);
        tick(2);
        check("data", shift_data_reg, 8'hFF);
        check("cnt", cnt_value, 8'h00);
        check("ovf", counter_overflow_flag, 8'h01);
        tick(3);
        check("ovf", counter_overflow_flag, 8'h01);
        pulse(ovf_clear, 1);
        tick(2);
        check("ovf", counter_overflow_flag, 8'h00);
        $display("done strobe");
    endtask

    task automatic t_pin(input logic sel, input logic [7:0] tx, input logic [7:0] dev);
        clock_edge_select = sel;
        clk_src = fsb_pkg::FSB_SRC_PIN;
        fsb_far_end_inst.park(sel);
        tick(10);
        data_wdata = dev;
        pulse(data_wr, 1);
        cnt_wdata = 4'h0;
        pulse(cnt_wr, 1);
        tick(2);
        fsb_far_end_inst.frame(tx, sel);
        tick(10);
        check("rx", shift_data_reg, tx);
        check("tx", far_rx, dev);
        check("cnt", cnt_value, 8'h00);
        check("ovf", counter_overflow_flag, 8'h01);
        ovf_irq_en = 1'b1;
        deep_sleep = 1'b1;
        tick(3);
        check("irq", irq_req, 8'h01);
        check("wake", wake_req, 8'h00);
        deep_sleep = 1'b0;
        tick(3);
        check("wake", wake_req, 8'h01);
        pulse(ovf_clear, 1);
        tick(3);
        check("irq", irq_req, 8'h00);
        ovf_irq_en = 1'b0;
        $display("done pin frame");
    endtask

    task automatic t_two();
        clk_src = fsb_pkg::FSB_SRC_SOFT;
        wire_mode = fsb_pkg::FSB_WIRE_TWO;
        clock_edge_select = 1'b0;
        data_wdata = 8'h00;
        pulse(data_wr, 1);
        tick(4);
        check("sda_oe_n", sda_oe_n, 8'h00);
        data_wdata = 8'h80;
        pulse(data_wr, 1);
        tick(4);
        check("sda_oe_n", sda_oe_n, 8'h01);
        hold_after_start = 1'b1;
        start_irq_en = 1'b1;
        deep_sleep = 1'b1;
        fsb_far_end_inst.start_cond();
        tick(4);
        check("start", start_detect_flag, 8'h01);
        check("scl_oe_n", scl_oe_n, 8'h00);
        check("irq", irq_req, 8'h01);
        check("wake", wake_req, 8'h01);
        pulse(start_clear, 1);
        tick(3);
        check("start", start_detect_flag, 8'h00);
        check("scl_oe_n", scl_oe_n, 8'h01);
        // The slave also stretches the clock after a byte until the flag is cleared.
        hold_after_ovf = 1'b1;
        cnt_wdata = 4'h8;
        pulse(cnt_wr, 1);
        pulse(soft_strobe, 8);
        tick(2);
        check("ovf", counter_overflow_flag, 8'h01);
        check("cnt", cnt_value, 8'h00);
        check("scl_oe_n", scl_oe_n, 8'h00);
        check("scl_o", scl_o, 8'h00);
        check("sda_o", sda_o, 8'h00);
        pulse(ovf_clear, 1);
        tick(2);
        check("ovf", counter_overflow_flag, 8'h00);
        check("scl_oe_n", scl_oe_n, 8'h01);
        hold_after_ovf = 1'b0;
        $display("done two-wire");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Reset for six cycles, then the scenarios in order.
    initial begin
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        t_reset();
        t_strobe();
        t_pin(1'b0, 8'h3C, 8'hA6);
        t_pin(1'b1, 8'hC3, 8'h59);
        t_two();
        conclude();
    end
endmodule
